// [verilog/adc_seq_defines.svh]
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// register offsets
`define OFF_LOWER_LOW 8'hC6
`define OFF_LOWER_HIGH 8'hC7
`define OFF_CONTROL 8'hE8
`define OFF_UPPER_LOW 8'hC4
`define OFF_UPPER_HIGH 8'hC5
`define OFF_RESULT_LOW 8'hBE
`define OFF_RESULT_HIGH 8'hBF
`define OFF_CHANNEL_SEL 8'hBB
`define OFF_PAIR_CFG 8'hBA
`define OFF_CONV_CFG 8'hBC
`define OFF_REF_CTRL 8'hD1
`define OFF_IRQ_MASK 8'hD2

// control bit positions
`define CTL_ENABLE 7
`define CTL_TRACK 6
`define CTL_DONE 5
`define CTL_BUSY 4
`define CTL_SRC_HI 3
`define CTL_SRC_LO 2
`define CTL_WIN 1
`define CTL_LJUST 0

// status/mask bit positions (mask register layout)
`define IRQ_DONE 5
`define IRQ_WIN 1

// start source encodings
`define SRC_SOFT 2'h0
`define SRC_TMR3 2'h1
`define SRC_EXT 2'h2
`define SRC_TMR2 2'h3

// reset values
`define RST_CONTROL 8'h00
`define RST_PAIR_CFG 8'h00
`define RST_CHANNEL 8'h00
`define RST_CONV_CFG 8'hF9
`define RST_REF_CTRL 8'h00
`define RST_LOWER 16'h0000
`define RST_UPPER 16'hFFFF
`define RST_MASK 8'h00

// converter config fields
`define GAIN_HI 2
`define GAIN_LO 0
`define SARDIV_HI 7
`define SARDIV_LO 3
`define BIAS_BIT 1

// timing: track window in SAR clocks
`define TRACK_SAR_CLKS 4'h3
`define CHAN_TEMP 4'h8
`define CHAN_MAX 4'h8
`define RES_BITS 12
`define RES_PAD 4'h0

`endif

// [verilog/adc_seq_pkg.sv]
package adc_seq_pkg;
  typedef enum logic [1:0] {
    st_idle,
    st_track,
    st_convert
  } seq_state_t;

  typedef struct packed {
    seq_state_t state;
    logic [7:0] control;
    logic [15:0] lower;
    logic [15:0] upper;
    logic [7:0] channel;
    logic [7:0] pair_cfg;
    logic [7:0] conv_cfg;
    logic [7:0] ref_ctrl;
    logic [7:0] irq_mask;
    logic [15:0] result;
    logic [4:0] div_cnt;
    logic [3:0] sar_cnt;
    logic ext_prev;
    logic [7:0] rdata;
  } seq_regs_t;
endpackage : adc_seq_pkg

// [verilog/adc_sequencer_window_detect.sv]
// Functional notes
// - enable bit low keeps converter, track-hold and gain stage shut down.
// - track mode 0 tracks continuously while enabled, except during conversion.
// - track mode 1: triggered sources track 3 SAR clocks; external tracks when pin low.
// - start field picks busy write, timer 3, pin rising edge, timer 2.
// - busy write of 1 starts only with source 00; writing 0 does nothing.
// - busy reads 1 while converting; its falling edge can raise an interrupt.
// - done flag set at conversion end, held until software clears it.
// - justify bit selects right or left placement of the result word.
// - window detector compares each result against two 16-bit limits.
// - each limit word is high byte above separately written low byte.
// - limit ordering chooses inside-window or outside-window detection.
// - window flag is interruptible or polled, sticky until software clears.
// - nine selector channels; ninth is temperature sensor through the gain.
// - input pairs individually differential or single-ended, changeable live.
// - reset makes every selector input single-ended.
// - three-bit gain field picks 0.5 to 16, unity after reset.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"

// ----------------------------------------------------------------
// sequencer around the converter core: start gating, tracking,
// result placement, window detector and interrupt flags
// ----------------------------------------------------------------

module adc_sequencer_window_detect
  import adc_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic timer3_ovf,
  input wire logic timer2_ovf,
  input wire logic ext_convert_start,
  input wire logic sar_done,
  input wire logic [11:0] sar_data,
  output logic conv_power_on,
  output logic track_hold,
  output logic sar_start,
  output logic sar_clk_en,
  output logic [3:0] input_selector,
  output logic [3:0] pair_diff,
  output logic [2:0] gain_select,
  output logic bias_enable,
  output logic irq
);

  seq_regs_t q_r;
  seq_regs_t q_nxt;

  logic conv_enable;
  logic track_mode_sel;
  logic [1:0] start_source_sel;
  logic left_justify_sel;
  logic trigger;
  logic soft_start;
  logic sar_tick;
  logic [15:0] placed;
  logic window_hit;
  logic done_evt;
  logic win_evt;
  logic [15:0] cmp_val;
  logic [7:0] ctl_eff;
  logic ctl_write;
  logic en_eff;
  logic track_eff;
  logic [1:0] src_eff;
  logic inside_hit;
  logic outside_hit;
  logic done_irq;
  logic win_irq;

  assign conv_enable = q_r.control[`CTL_ENABLE];
  assign track_mode_sel = q_r.control[`CTL_TRACK];
  assign start_source_sel = q_r.control[`CTL_SRC_HI:`CTL_SRC_LO];
  assign left_justify_sel = q_r.control[`CTL_LJUST];

  // ----------------------------------------------------------------
  // effective control
  // ----------------------------------------------------------------
  // a control write counts for its own start request, so one write
  // can enable the converter, pick the source and start at once
  assign ctl_write = wr_en && addr == `OFF_CONTROL;
  assign ctl_eff = ctl_write ? wdata : q_r.control;
  assign en_eff = ctl_eff[`CTL_ENABLE];
  assign track_eff = ctl_eff[`CTL_TRACK];
  assign src_eff = ctl_eff[`CTL_SRC_HI:`CTL_SRC_LO];

  // ----------------------------------------------------------------
  // start sources
  // ----------------------------------------------------------------
  assign soft_start = ctl_write && wdata[`CTL_BUSY]
    && src_eff == `SRC_SOFT;

  // pin level is taken as synchronous; no synchroniser in front of it
  always_comb begin
    case (src_eff)
      `SRC_SOFT: begin
        trigger = soft_start;
      end
      `SRC_TMR3: begin
        trigger = timer3_ovf;
      end
      `SRC_EXT: begin
        trigger = ext_convert_start && !q_r.ext_prev;
      end
      `SRC_TMR2: begin
        trigger = timer2_ovf;
      end
      default: begin
        trigger = 1'b0;
      end
    endcase
  end

  // one SAR clock every divider+1 system clocks

  assign sar_tick = q_r.div_cnt == q_r.conv_cfg[`SARDIV_HI:`SARDIV_LO];

  // ----------------------------------------------------------------
  // result placement and window compare
  // ----------------------------------------------------------------
  assign placed = left_justify_sel ?
    {sar_data, `RES_PAD} : {`RES_PAD, sar_data};
  assign cmp_val = placed;

  // strict bounds: a result equal to either limit never hits
  assign inside_hit = cmp_val > q_r.upper && cmp_val < q_r.lower;
  assign outside_hit = cmp_val < q_r.lower || cmp_val > q_r.upper;

  always_comb begin
    // ordering of the limits picks the window sense
    if (q_r.lower > q_r.upper) begin
      window_hit = inside_hit;
    end else begin
      window_hit = outside_hit;
    end
  end

  assign done_evt = q_r.state == st_convert && sar_done;
  assign win_evt = done_evt && window_hit;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    q_nxt.ext_prev = ext_convert_start;
    q_nxt.div_cnt = sar_tick ? 5'h00 : q_r.div_cnt + 5'h01;

    case (q_r.state)
      st_idle: begin
        if (en_eff && trigger) begin
          q_nxt.sar_cnt = 4'h0;
          q_nxt.div_cnt = 5'h00;
          if (track_eff && src_eff != `SRC_EXT) begin
            q_nxt.state = st_track;
          end else begin
            q_nxt.state = st_convert;
          end
        end
      end
      st_track: begin
        if (sar_tick) begin
          q_nxt.sar_cnt = q_r.sar_cnt + 4'h1;
          if (q_r.sar_cnt == `TRACK_SAR_CLKS - 4'h1) begin
            q_nxt.state = st_convert;
          end
        end
      end
      st_convert: begin
        if (sar_done) begin
          q_nxt.state = st_idle;
          q_nxt.result = placed;
        end
      end
      default: begin
        q_nxt.state = st_idle;
      end
    endcase
    // disabling aborts a running conversion; its result is dropped unless sar_done arrives in the same cycle
    if (!en_eff) begin
      q_nxt.state = st_idle;
    end

    // software writes
    if (wr_en) begin
      case (addr)
        `OFF_CONTROL: begin
          q_nxt.control[`CTL_ENABLE] = wdata[`CTL_ENABLE];
          q_nxt.control[`CTL_TRACK] = wdata[`CTL_TRACK];
          q_nxt.control[`CTL_SRC_HI:`CTL_SRC_LO] =
            wdata[`CTL_SRC_HI:`CTL_SRC_LO];
          q_nxt.control[`CTL_LJUST] = wdata[`CTL_LJUST];
          // flags clear by writing zero, never set by software
          if (!wdata[`CTL_DONE]) begin
            q_nxt.control[`CTL_DONE] = 1'b0;
          end
          if (!wdata[`CTL_WIN]) begin
            q_nxt.control[`CTL_WIN] = 1'b0;
          end
        end
        `OFF_LOWER_LOW: begin
          q_nxt.lower[7:0] = wdata;
        end
        `OFF_LOWER_HIGH: begin
          q_nxt.lower[15:8] = wdata;
        end
        `OFF_UPPER_LOW: begin
          q_nxt.upper[7:0] = wdata;
        end
        `OFF_UPPER_HIGH: begin
          q_nxt.upper[15:8] = wdata;
        end
        `OFF_CHANNEL_SEL: begin
          q_nxt.channel = wdata;
        end
        `OFF_PAIR_CFG: begin
          q_nxt.pair_cfg = wdata;
        end
        `OFF_CONV_CFG: begin
          q_nxt.conv_cfg = wdata;
        end
        `OFF_REF_CTRL: begin
          q_nxt.ref_ctrl = wdata;
        end
        `OFF_IRQ_MASK: begin
          q_nxt.irq_mask = wdata;
        end
        default: begin
          q_nxt.rdata = q_nxt.rdata;
        end
      endcase
    end

    // hardware set wins over a same-cycle clear
    if (done_evt) begin
      q_nxt.control[`CTL_DONE] = 1'b1;
    end
    if (win_evt) begin
      q_nxt.control[`CTL_WIN] = 1'b1;
    end
    q_nxt.control[`CTL_BUSY] = q_nxt.state != st_idle;

    // read data, one cycle after the strobe only
    q_nxt.rdata = 8'h00;
    if (rd_en) begin
      case (addr)
        `OFF_CONTROL: begin
          q_nxt.rdata = q_r.control;
        end
        `OFF_LOWER_LOW: begin
          q_nxt.rdata = q_r.lower[7:0];
        end
        `OFF_LOWER_HIGH: begin
          q_nxt.rdata = q_r.lower[15:8];
        end
        `OFF_UPPER_LOW: begin
          q_nxt.rdata = q_r.upper[7:0];
        end
        `OFF_UPPER_HIGH: begin
          q_nxt.rdata = q_r.upper[15:8];
        end
        `OFF_RESULT_LOW: begin
          q_nxt.rdata = q_r.result[7:0];
        end
        `OFF_RESULT_HIGH: begin
          q_nxt.rdata = q_r.result[15:8];
        end
        `OFF_CHANNEL_SEL: begin
          q_nxt.rdata = q_r.channel;
        end
        `OFF_PAIR_CFG: begin
          q_nxt.rdata = q_r.pair_cfg;
        end
        `OFF_CONV_CFG: begin
          q_nxt.rdata = q_r.conv_cfg;
        end
        `OFF_REF_CTRL: begin
          q_nxt.rdata = q_r.ref_ctrl;
        end
        `OFF_IRQ_MASK: begin
          q_nxt.rdata = q_r.irq_mask;
        end
        default: begin
          q_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q_r.state <= st_idle;
      q_r.control <= `RST_CONTROL;
      q_r.lower <= `RST_LOWER;
      q_r.upper <= `RST_UPPER;
      q_r.channel <= `RST_CHANNEL;
      q_r.pair_cfg <= `RST_PAIR_CFG;
      q_r.conv_cfg <= `RST_CONV_CFG;
      q_r.ref_ctrl <= `RST_REF_CTRL;
      q_r.irq_mask <= `RST_MASK;
      q_r.result <= 16'h0000;
      q_r.div_cnt <= 5'h00;
      q_r.sar_cnt <= 4'h0;
      q_r.ext_prev <= 1'b0;
      q_r.rdata <= 8'h00;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs to the analog side
  // ----------------------------------------------------------------
  assign rdata = q_r.rdata;
  assign conv_power_on = conv_enable;
  always_comb begin
    if (!conv_enable) begin
      track_hold = 1'b0;
    end else if (!track_mode_sel) begin
      track_hold = q_r.state != st_convert;
    end else if (start_source_sel == `SRC_EXT) begin
      track_hold = !ext_convert_start && q_r.state == st_idle;
    end else begin
      track_hold = q_r.state == st_track;
    end
  end
  assign sar_start = q_r.state == st_convert;
  assign sar_clk_en = sar_tick && q_r.state == st_convert;

  // ----------------------------------------------------------------
  // selector, pairs and gain
  // ----------------------------------------------------------------
  // low-nibble channel values above the ninth clamp to the temperature sensor; upper bits are ignored
  assign input_selector = q_r.channel[3:0] > `CHAN_MAX ?
    `CHAN_TEMP : q_r.channel[3:0];
  // one bit per selector pair; pairs switch independently
  genvar pi;
  generate
    for (pi = 0; pi < $bits(pair_diff); pi++) begin : g_pair
      assign pair_diff[pi] = q_r.pair_cfg[pi];
    end
  endgenerate
  assign gain_select = q_r.conv_cfg[`GAIN_HI:`GAIN_LO];
  assign bias_enable = q_r.ref_ctrl[`BIAS_BIT];

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  // level output: high until software clears the flag or masks it
  assign done_irq = q_r.control[`CTL_DONE] && q_r.irq_mask[`IRQ_DONE];
  assign win_irq = q_r.control[`CTL_WIN] && q_r.irq_mask[`IRQ_WIN];
  assign irq = done_irq || win_irq;

endmodule : adc_sequencer_window_detect
`default_nettype wire

// [tb/adc_seq_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_seq_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic sar_done,
  input wire logic conv_power_on,
  input wire logic track_hold,
  input wire logic sar_start,
  input wire logic [3:0] pair_diff,
  input wire logic [2:0] gain_select,
  input wire logic irq
);
  // ----
  // port relations
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_pwr;
    wr_en && addr == 8'hE8 |=> conv_power_on == $past(wdata[7]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power bit mismatch");
  property p_off;
    !conv_power_on |-> !sar_start && !track_hold;
  endproperty
  a_off: assert property (p_off) else $error("active while off");
  property p_soft;
    wr_en && addr == 8'hE8 && wdata[7:2] == 6'h24 && !sar_start |=> sar_start;
  endproperty
  a_soft: assert property (p_soft) else $error("soft start lost");
  property p_end;
    sar_start && sar_done |=> !sar_start;
  endproperty
  a_end: assert property (p_end) else $error("busy after done");
  property p_cnv;
    sar_start |-> !track_hold;
  endproperty
  a_cnv: assert property (p_cnv) else $error("tracking in convert");
  // flags only drop through a register write
  property p_irq;
    irq && !wr_en |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq dropped");
  property p_gain;
    wr_en && addr == 8'hBC |=> gain_select == $past(wdata[2:0]);
  endproperty
  a_gain: assert property (p_gain) else $error("gain mismatch");
  property p_diff;
    wr_en && addr == 8'hBA |=> pair_diff == $past(wdata[3:0]);
  endproperty
  a_diff: assert property (p_diff) else $error("pair mismatch");
endmodule : adc_seq_checker
bind adc_sequencer_window_detect adc_seq_checker u_chk (.ref_clk(ref_clk),
  .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .irq(irq),
  .sar_done(sar_done), .conv_power_on(conv_power_on), .pair_diff(pair_diff),
  .track_hold(track_hold), .sar_start(sar_start), .gain_select(gain_select));
`default_nettype wire

// [tb/sar_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_core_model (
  input wire logic ref_clk,
  input wire logic sar_start,
  input wire logic [3:0] lat,
  input wire logic [11:0] sample,
  output logic sar_done,
  output logic [11:0] sar_data
);
  // ----
  // converter core
  // ----
  logic [3:0] cnt_r;
  initial cnt_r = 4'h0;
  // data is only valid in the done cycle, so drive junk elsewhere
  always @(posedge ref_clk) begin
    sar_done <= 1'b0;
    sar_data <= ~sample;
    cnt_r <= 4'h0;
    if (sar_start && !sar_done) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == lat) begin
        sar_done <= 1'b1;
        sar_data <= sample;
      end
    end
  end
endmodule : sar_core_model
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  err_total++; $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  logic ref_clk, nrst, wr_en, rd_en, timer3_ovf, timer2_ovf, sar_done;
  logic ext_convert_start, conv_power_on, track_hold, sar_start, irq;
  logic bias_enable;
  logic [7:0] addr, wdata, rdata;
  logic [11:0] sar_data, sample;
  logic [3:0] lat, input_selector, pair_diff;
  logic [2:0] gain_select;
  int err_total, samples_checked, cyc;
  adc_sequencer_window_detect u_adc_sequencer_window_detect (
    .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .timer3_ovf(timer3_ovf),
    .timer2_ovf(timer2_ovf), .ext_convert_start(ext_convert_start),
    .sar_done(sar_done), .sar_data(sar_data), .sar_clk_en(),
    .conv_power_on(conv_power_on), .track_hold(track_hold),
    .sar_start(sar_start), .input_selector(input_selector),
    .pair_diff(pair_diff), .gain_select(gain_select),
    .bias_enable(bias_enable), .irq(irq));
  sar_core_model u_sar_core_model (.ref_clk(ref_clk), .sar_start(sar_start),
    .lat(lat), .sample(sample), .sar_done(sar_done), .sar_data(sar_data));
  // ----
  // clock, timeout, bus tasks
  // ----
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask : rd
  // pin stays at its level until the next trigger so edges are clean
  task automatic pulse(input int k);
    @(posedge ref_clk);
    timer3_ovf <= (k == 1);
    ext_convert_start <= (k == 2);
    timer2_ovf <= (k == 3);
    @(posedge ref_clk);
    timer3_ovf <= 1'b0;
    timer2_ovf <= 1'b0;
    #1;
  endtask : pulse
  task automatic wait_idle();
    int n;
    n = 0;
    while (sar_start !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    while (sar_start === 1'b1 && n < 900) begin
      @(posedge ref_clk);
      n++;
    end
    #1;
    `CHK("conversion", 1'b1, n < 900)
  endtask : wait_idle
  // ----
  // scenarios
  // ----
  initial begin
    {nrst, addr, wdata, wr_en, rd_en, timer3_ovf, timer2_ovf} = '0;
    ext_convert_start = 1'b0;
    lat = 4'h2;
    sample = 12'h050;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    #1;
    `CHK("gain", 3'h1, gain_select)
    `CHK("pairs", 4'h0, pair_diff)
    rd(8'hE8, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'hD1, 8'h02);
    `CHK("bias", 1'b1, bias_enable)
    wr(8'hD2, 8'h22);
    wr(8'hC7, 8'h01);
    wr(8'hC6, 8'h00);
    wr(8'hC5, 8'h02);
    wr(8'hC4, 8'h00);
    wr(8'hE8, 8'h10);
    `CHK("off start", 1'b0, sar_start)
    `CHK("power off", 1'b0, conv_power_on)
    wr(8'hE8, 8'h90);
    `CHK("power on", 1'b1, conv_power_on)
    wait_idle();
    rd(8'hE8, 8'hA2);
    rd(8'hBE, 8'h50);
    `CHK("irq", 1'b1, irq)
    wr(8'hD2, 8'h00);
    `CHK("masked", 1'b0, irq)
    wr(8'hD2, 8'h22);
    wr(8'hE8, 8'h80);
    `CHK("idle track", 1'b1, track_hold)
    `CHK("irq clear", 1'b0, irq)
    wr(8'hE8, 8'hA2);
    rd(8'hE8, 8'h80);
    lat = 4'hC;
    sample = 12'h150;
    wr(8'hE8, 8'h91);
    wait_idle();
    rd(8'hE8, 8'hA3);
    rd(8'hBF, 8'h15);
    wr(8'hE8, 8'h94);
    `CHK("no soft start", 1'b0, sar_start)
    for (int s = 1; s < 4; s++) begin
      wr(8'hE8, 8'(8'h80 | (s << 2)));
      pulse((s % 3) + 1);
      `CHK("wrong source", 1'b0, sar_start)
      pulse(s);
      wait_idle();
      rd(8'hE8, 8'(8'hA0 | (s << 2)));
    end
    wr(8'hC7, 8'h03);
    wr(8'hC5, 8'h01);
    wr(8'hE8, 8'h80);
    wr(8'hE8, 8'h90);
    wait_idle();
    rd(8'hE8, 8'hA2);
    wr(8'hE8, 8'hD0);
    `CHK("track first", 2'b10, {track_hold, sar_start})
    wait_idle();
    rd(8'hE8, 8'hE2);
    for (int g = 0; g < 6; g++) begin
      wr(8'hBC, {5'h1F, 3'(g)});
      `CHK("gain sel", 3'(g), gain_select)
    end
    wr(8'hBB, 8'h09);
    `CHK("channel", 4'h8, input_selector)
    wr(8'hBA, 8'h05);
    `CHK("pair cfg", 4'h5, pair_diff)
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
